// >>> qps_pkg.sv
/*
 * qps_pkg: constants and types for the quad rail power sequencer.
 * assumes a single 20 MHz clock domain.
 */
package qps_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned QPS_CLOCK_HZ = 20_000_000;
	localparam int unsigned QPS_DELAY_MS = 190;
	localparam int unsigned QPS_DELAY_CYCLES = (QPS_CLOCK_HZ / 1000) * QPS_DELAY_MS;
	localparam int unsigned QPS_CNT_W = 23;
	localparam int unsigned QPS_SENSE_N = 4;

	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		QPS_WAIT_FIRST = 3'h0,
		QPS_DELAY_FIRST = 3'h1,
		QPS_CHAIN = 3'h2,
		QPS_DELAY_GOOD = 3'h3,
		QPS_GOOD = 3'h4
	} qps_state_t;
endpackage : qps_pkg

// >>> qps_delay_if.sv
/*
 * qps_delay_if: run/done link between the sequencer and its delay counter.
 * assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface qps_delay_if;
	logic run;
	logic done;
	modport ctrl (output run, input done);
	modport timer (input run, output done);
endinterface : qps_delay_if
`default_nettype wire

// >>> qps_delay_timer.sv
/*
 * qps_delay_timer: counts while run is high, done once the terminal count is reached.
 * assumes run drops to restart the count.
 */
`timescale 1ns/1ps
`default_nettype none
module qps_delay_timer
	import qps_pkg::*;
#(
	parameter int unsigned TERMINAL = QPS_DELAY_CYCLES
) (
	input wire logic clock,
	input wire logic arst_n,
	qps_delay_if.timer dly
);
	logic [QPS_CNT_W-1:0] count_reg;

	// ---------------------------------------------------------------
	// counter, cleared whenever run is low
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
		end else if (!dly.run) begin
			count_reg <= '0;
		end else if (count_reg != QPS_CNT_W'(TERMINAL)) begin
			count_reg <= count_reg + QPS_CNT_W'(1);
		end
	end

	assign dly.done = dly.run && (count_reg == QPS_CNT_W'(TERMINAL));
endmodule : qps_delay_timer
`default_nettype wire

// >>> qps_sequencer.sv
/*
 * qps_sequencer: quad rail sequencer, three chained regulator enables and power good.
 * assumes comparator flags from outside the clock domain, high when rail is above 0.6 V.
 */
// Function
// - while the first rail is below threshold the first enable stays low.
// - the first enable rises 190 ms after the first rail reaches threshold.
// - the second rail above threshold raises the second enable, the third likewise the third.
// - power good is formed from the AND of the three enables after the last supply is up.
// - power good asserts 190 ms after its condition becomes true.
// - any rail below threshold during power-up keeps power good low.
// - with all rails up and power good asserted, the block latches into a power-good mode.
// - in that mode a first-rail fault drops power good and all enables at once.
// - in that mode a fault on rails two to four drops power good only.
// - any rail below the 0.6 V threshold counts as a fault.
// - enables are active high, driven low when off.
`timescale 1ns/1ps
`default_nettype none
module qps_sequencer
	import qps_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = QPS_DELAY_CYCLES
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic rail_sense_first,
	input wire logic rail_sense_second,
	input wire logic rail_sense_third,
	input wire logic rail_sense_fourth,
	output logic regulator_enable_first,
	output logic regulator_enable_second,
	output logic regulator_enable_third,
	output logic system_power_good
);
	logic [QPS_SENSE_N-1:0] sense_raw;
	logic [QPS_SENSE_N-1:0] sync1_reg;
	logic [QPS_SENSE_N-1:0] sync2_reg;
	qps_state_t state_reg;
	qps_state_t state_next;
	logic en1_next;
	logic en2_next;
	logic en3_next;
	logic good_next;
	logic all_up;

	qps_delay_if dly ();

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	assign sense_raw = {rail_sense_fourth, rail_sense_third, rail_sense_second,
		rail_sense_first};

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= sense_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// a low flag means the rail is under 0.6 V
	assign all_up = &sync2_reg;

	// ---------------------------------------------------------------
	// shared delay counter
	// ---------------------------------------------------------------
	qps_delay_timer #(
		.TERMINAL(DELAY_CYCLES)
	) u_timer (
		.clock(clock),
		.arst_n(arst_n),
		.dly(dly)
	);

	assign dly.run = ((state_reg == QPS_DELAY_FIRST) && sync2_reg[0]) ||
		((state_reg == QPS_DELAY_GOOD) && all_up);

	// ---------------------------------------------------------------
	// next state and outputs
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		en1_next = 1'b0;
		en2_next = 1'b0;
		en3_next = 1'b0;
		good_next = 1'b0;
		case (state_reg)
			QPS_WAIT_FIRST: begin
				if (sync2_reg[0]) begin
					state_next = QPS_DELAY_FIRST;
				end
			end
			QPS_DELAY_FIRST: begin
				if (!sync2_reg[0]) begin
					state_next = QPS_WAIT_FIRST;
				end else if (dly.done) begin
					state_next = QPS_CHAIN;
					en1_next = 1'b1;
				end
			end
			QPS_CHAIN, QPS_DELAY_GOOD: begin
				en1_next = sync2_reg[0];
				en2_next = sync2_reg[0] && sync2_reg[1];
				en3_next = en2_next && sync2_reg[2];
				if (!sync2_reg[0]) begin
					state_next = QPS_WAIT_FIRST;
				end else if (state_reg == QPS_CHAIN) begin
					if (en1_next && en2_next && en3_next && sync2_reg[3]) begin
						state_next = QPS_DELAY_GOOD;
					end
				end else if (!all_up) begin
					state_next = QPS_CHAIN;
				end else if (dly.done) begin
					state_next = QPS_GOOD;
					good_next = en1_next && en2_next && en3_next;
				end
			end
			QPS_GOOD: begin
				if (!sync2_reg[0]) begin
					state_next = QPS_WAIT_FIRST;
				end else begin
					en1_next = 1'b1;
					en2_next = 1'b1;
					en3_next = 1'b1;
					good_next = all_up;
				end
			end
			default: begin
				state_next = QPS_WAIT_FIRST;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= QPS_WAIT_FIRST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ---------------------------------------------------------------
	// registered outputs, active high enables
	// ---------------------------------------------------------------
	// first enable, low whenever rail one is not confirmed up
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			regulator_enable_first <= 1'b0;
		end else begin
			regulator_enable_first <= en1_next;
		end
	end

	// second enable, follows the chain from the first
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			regulator_enable_second <= 1'b0;
		end else begin
			regulator_enable_second <= en2_next;
		end
	end

	// third enable, follows the chain from the second
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			regulator_enable_third <= 1'b0;
		end else begin
			regulator_enable_third <= en3_next;
		end
	end

	// power good, only ever set from the delay or good states
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			system_power_good <= 1'b0;
		end else begin
			system_power_good <= good_next;
		end
	end
endmodule : qps_sequencer
`default_nettype wire

// >>> qps_seq_props.sv
/* qps_seq_props: port-level timing checks of the sequencer.
 * assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module qps_seq_props
	import qps_pkg::*;
#(parameter int unsigned DELAY_CYCLES = QPS_DELAY_CYCLES) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic rail_sense_first,
	input wire logic rail_sense_second,
	input wire logic rail_sense_third,
	input wire logic rail_sense_fourth,
	input wire logic regulator_enable_first,
	input wire logic regulator_enable_second,
	input wire logic regulator_enable_third,
	input wire logic system_power_good
);
	wire logic all_up = rail_sense_first && rail_sense_second &&
		rail_sense_third && rail_sense_fourth;
	wire logic all_en = regulator_enable_first && regulator_enable_second &&
		regulator_enable_third;
	int unsigned up1;
	int unsigned upall;
	logic seen;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// run lengths of rail one and of all rails; seen marks power-good mode
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			up1 <= 0;
			upall <= 0;
			seen <= 1'b0;
		end else begin
			up1 <= rail_sense_first ? up1 + 1 : 0;
			upall <= all_up ? upall + 1 : 0;
			seen <= regulator_enable_first && (seen || system_power_good);
		end
	end
	sequence rail1_low_s; !rail_sense_first [*4]; endsequence
	sequence some_low_s; !all_up [*4]; endsequence
	sequence rail1_held_s; rail_sense_first [*6]; endsequence
	en1_held_a: assert property (rail1_low_s |-> !regulator_enable_first)
		else $error("first enable up with rail one low");
	en1_delay_a: assert property (
		$rose(regulator_enable_first) |-> up1 >= DELAY_CYCLES)
		else $error("first enable rose early");
	chain_two_a: assert property (
		(regulator_enable_first && rail_sense_second) [*6] |-> regulator_enable_second)
		else $error("second enable missing");
	chain_order_a: assert property (
		(regulator_enable_third |-> regulator_enable_second) and
		(regulator_enable_second |-> regulator_enable_first))
		else $error("enable out of chain order");
	good_and_a: assert property (system_power_good |-> all_en)
		else $error("power good without all enables");
	good_delay_a: assert property (
		$rose(system_power_good) && !seen |-> upall >= DELAY_CYCLES)
		else $error("power good rose early");
	good_low_a: assert property (some_low_s |-> !system_power_good)
		else $error("power good with a rail low");
	first_fault_a: assert property (
		$fell(regulator_enable_first) |-> !regulator_enable_second &&
		!regulator_enable_third && !system_power_good)
		else $error("outputs not dropped together");
	keep_en_a: assert property (rail1_held_s ##0 seen |-> all_en)
		else $error("enable dropped in power good mode");
endmodule : qps_seq_props
bind qps_sequencer qps_seq_props #(.DELAY_CYCLES(DELAY_CYCLES)) u_props (.clock, .arst_n,
	.rail_sense_first, .rail_sense_second, .rail_sense_third, .rail_sense_fourth,
	.regulator_enable_first, .regulator_enable_second, .regulator_enable_third,
	.system_power_good);
`default_nettype wire

// >>> qps_rail_model.sv
/* qps_rail_model: three regulators whose outputs feed sense inputs two to four.
 * assumes rail one is driven elsewhere; fail forces a rail below threshold. */
`timescale 1ns/1ps
`default_nettype none
module qps_rail_model #(parameter int LAG = 3) (
	input wire logic clock,
	input wire logic [2:0] enable,
	input wire logic [2:0] fail,
	output logic [2:0] sense
);
	int ramp [3];
	// each output ramps LAG cycles after its enable, drops on the next clock edge when disabled
	always_ff @(posedge clock) begin
		for (int i = 0; i < 3; i++) begin
			ramp[i] <= enable[i] ? ((ramp[i] < LAG) ? ramp[i] + 1 : LAG) : 0;
		end
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			sense[i] = (ramp[i] >= LAG) && !fail[i];
		end
	end
endmodule : qps_rail_model
`default_nettype wire

// >>> tb.sv
/* tb: power-up, restart and fault scenarios of the sequencer.
 * assumes the rail model closes the chain from enables to sense inputs. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int unsigned D = 20;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic s1 = 1'b0;
	logic [2:0] fail = 3'h0;
	logic [2:0] en;
	logic [2:0] sense;
	logic pg;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	qps_sequencer #(.DELAY_CYCLES(D)) uut (.clock, .arst_n, .rail_sense_first(s1),
		.rail_sense_second(sense[0]), .rail_sense_third(sense[1]), .rail_sense_fourth(sense[2]),
		.regulator_enable_first(en[0]), .regulator_enable_second(en[1]),
		.regulator_enable_third(en[2]), .system_power_good(pg));
	qps_rail_model #(.LAG(3)) u_rails (.clock, .enable(en), .fail, .sense);
	initial forever #25 clock = ~clock;
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	always @(posedge clock) begin
		cyc++;
		if (cyc == 1000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic chk(string name, logic [3:0] got, logic [3:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic step(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic drive(logic v1, logic [2:0] f);
		@(posedge clock);
		s1 <= v1;
		fail <= f;
	endtask : drive
	task automatic t_power_up();
		drive(1'b0, 3'h4);
		step(10);
		chk("outputs", {pg, en}, 4'h0);
		drive(1'b1, 3'h4);
		step(D / 2);
		drive(1'b0, 3'h4);
		drive(1'b1, 3'h4);
		step(D);
		chk("outputs", {pg, en}, 4'h0);
		for (int i = 0; i < 20 && en[0] !== 1'b1; i++) step(1);
		step(20);
		chk("outputs", {pg, en}, 4'h7);
		step(2 * D);
		chk("outputs", {pg, en}, 4'h7);
		drive(1'b1, 3'h0);
		step(D);
		chk("outputs", {pg, en}, 4'h7);
		for (int i = 0; i < 30 && pg !== 1'b1; i++) step(1);
		chk("outputs", {pg, en}, 4'hF);
	endtask : t_power_up
	task automatic t_late_fault();
		drive(1'b1, 3'h2);
		step(6);
		chk("outputs", {pg, en}, 4'h7);
		drive(1'b1, 3'h0);
		step(8);
		chk("outputs", {pg, en}, 4'hF);
		drive(1'b0, 3'h0);
		step(6);
		chk("outputs", {pg, en}, 4'h0);
	endtask : t_late_fault
	initial begin
		step(5);
		chk("outputs", {pg, en}, 4'h0);
		@(posedge clock);
		arst_n <= 1'b1;
		t_power_up();
		t_late_fault();
		test_done();
	end
endmodule : tb
`default_nettype wire
